/* File: core/uart_baud_tx.sv */
// Baud generator, register file and asynchronous/synchronous transmitter
//
// Summary of operation
// - Dedicated 8-bit free-running timer sets the period
// - High-speed bit also sets async rate
// - Synchronous mode ignores the high-speed bit
// - Divisor rates apply in async mode and to internal-clock master
// - Async rate: clock over 64 or 16 times N+1
// - Sync rate: clock over 4 times N+1
// - Divisor is unsigned register value, 0 to 255
// - Divisor write clears the generator timer
// - Setting transmit enable raises transmit flag
// - Writing transmit data starts a frame while port and transmit are enabled
`timescale 1ns/100ps
`include "uart_baud_map.svh"

module uart_baud_tx (
   // Clock and reset
   input wire logic clk_i,
   input wire logic resetn_i,
   // Register port
   input wire uart_baud_pkg::byte_t addr_i,
   input wire uart_baud_pkg::byte_t wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output uart_baud_pkg::byte_t rdata_o,
   // Serial pins
   output logic tx_o,
   input wire logic ck_i,
   output logic ck_o,
   output logic ck_oe_o,
   // Interrupt
   output logic irq_o
);
   import uart_baud_pkg::*;

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   byte_t tx_status_control; // Mode and enable bits
   byte_t rx_status_control; // Port enable and receive controls
   byte_t baud_divisor; // Generator period minus one
   byte_t tx_data; // Holding register for the next frame
   byte_t peripheral_flags_1; // Sticky event flags
   byte_t peripheral_irq_enable_1; // Interrupt mask
   logic hold_full; // Holding register has a word
   logic transmit_enable_q; // Transmit enable one cycle ago
   tx_state_t state; // Shifter state

   // Field views
   logic clock_source_select;
   logic nine_bit_transmit_select;
   logic transmit_enable;
   logic sync_mode;
   logic high_speed_select;
   logic ninth_transmit_bit;
   logic serial_port_enable;
   logic shift_register_empty;
   assign clock_source_select = tx_status_control[`TXSC_CLOCK_SOURCE_SELECT];
   assign nine_bit_transmit_select = tx_status_control[`TXSC_TX9];
   assign transmit_enable = tx_status_control[`TXSC_TRANSMIT_ENABLE];
   assign sync_mode = tx_status_control[`TXSC_SYNC];
   assign high_speed_select = tx_status_control[`TXSC_HS];
   assign ninth_transmit_bit = tx_status_control[`TXSC_NINTH_TRANSMIT_BIT];
   assign serial_port_enable = rx_status_control[`RXSC_SERIAL_PORT_ENABLE];

   // Decoded strobes
   logic wr_txsc;
   logic wr_rxsc;
   logic wr_div;
   logic wr_data;
   logic wr_flags;
   logic wr_irqen;
   assign wr_txsc = wr_i && (addr_i == `OFS_TXSC);
   assign wr_rxsc = wr_i && (addr_i == `OFS_RXSC);
   assign wr_div = wr_i && (addr_i == `OFS_DIV);
   assign wr_data = wr_i && (addr_i == `OFS_TXDATA);
   assign wr_flags = wr_i && (addr_i == `OFS_FLAGS);
   assign wr_irqen = wr_i && (addr_i == `OFS_IRQEN);

   // ----------------------------------------
   // Control register writes
   // ----------------------------------------
   // Mode register; the empty flag bit is read from the shifter
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         tx_status_control <= `TXSC_RST;
      end else if (wr_txsc) begin
         tx_status_control <= wdata_i & `TXSC_WMASK;
      end
   end

   // Port enable register; receive status bits are absent
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         rx_status_control <= `RXSC_RST;
      end else if (wr_rxsc) begin
         rx_status_control <= wdata_i & `RXSC_WMASK;
      end
   end

   // Divisor, used unsigned over its whole range
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         baud_divisor <= `DIV_RST;
      end else if (wr_div) begin
         baud_divisor <= wdata_i;
      end
   end

   // Interrupt mask
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         peripheral_irq_enable_1 <= `IRQEN_RST;
      end else if (wr_irqen) begin
         peripheral_irq_enable_1 <= wdata_i;
      end
   end

   // ----------------------------------------
   // Baud generator
   // ----------------------------------------
   logic gen_tick; // One pulse per divisor-plus-one clocks
   byte_t gen_count; // Timer value
   logic int_clock; // Generator drives the bit clock
   assign int_clock = !sync_mode || clock_source_select;

   // Timer restarts on every divisor write
   baud_timer u_timer (
      .clk_i(clk_i),
      .resetn_i(resetn_i),
      .clear_i(wr_div),
      .run_i(serial_port_enable && int_clock),
      .divisor_i(baud_divisor),
      .tick_o(gen_tick),
      .count_o(gen_count)
   );

   // Prescaler ratio by mode; sync ignores the speed bit
   logic [5:0] pre_limit;
   always_comb begin
      if (sync_mode) begin
         pre_limit = `PRE_SYNC;
      end else if (high_speed_select) begin
         pre_limit = `PRE_HIGH;
      end else begin
         pre_limit = `PRE_LOW;
      end
   end

   logic [5:0] pre_cnt; // Generator ticks within one bit
   logic int_bit_tick; // Bit boundary from the generator
   assign int_bit_tick = gen_tick && (pre_cnt >= pre_limit);

   // Prescaler counts generator ticks, cleared on a divisor write and in slave mode
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         pre_cnt <= `PRE_ZERO;
      end else if (wr_div || !int_clock) begin
         pre_cnt <= `PRE_ZERO;
      end else if (int_bit_tick) begin
         pre_cnt <= `PRE_ZERO;
      end else if (gen_tick) begin
         pre_cnt <= pre_cnt + 6'h01;
      end
   end

   // ----------------------------------------
   // External clock in synchronous slave mode
   // ----------------------------------------
   logic ck_s1; // First synchroniser stage
   logic ck_s2; // Second synchroniser stage
   logic ck_s3; // Delayed copy for edge detection
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         ck_s1 <= 1'b1; // Idle high level, so no false edge follows reset
         ck_s2 <= 1'b1;
         ck_s3 <= 1'b1;
      end else begin
         ck_s1 <= ck_i;
         ck_s2 <= ck_s1;
         ck_s3 <= ck_s2;
      end
   end

   logic bit_tick; // Selected bit boundary
   assign bit_tick = int_clock ? int_bit_tick : (ck_s2 && !ck_s3);

   // ----------------------------------------
   // Clock pin in synchronous master mode
   // ----------------------------------------
   // Low for the first half of each bit after the first, high for the second
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         ck_o <= 1'b1;
      end else if (!(sync_mode && clock_source_select)) begin
         ck_o <= 1'b1;
      end else if (bit_tick && state == TX_SHIFT) begin
         ck_o <= 1'b0;
      end else if (gen_tick && pre_cnt == `PRE_HALF) begin
         ck_o <= 1'b1;
      end
   end
   assign ck_oe_o = serial_port_enable && sync_mode && clock_source_select;

   // ----------------------------------------
   // Holding register and shifter
   // ----------------------------------------
   logic [10:0] shreg; // Frame bits, first bit at the bottom
   logic [3:0] bits_left; // Bits still to send
   logic load; // Holding word moves into the shifter
   logic tx_ready; // Port and transmitter are on
   assign tx_ready = serial_port_enable && transmit_enable;
   assign load = tx_ready && hold_full && bit_tick && (state == TX_IDLE);
   assign shift_register_empty = (state == TX_IDLE);

   // A data write fills the holding register while transmit is enabled
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         tx_data <= `TXDATA_RST;
         hold_full <= 1'b0;
      end else if (!transmit_enable) begin
         hold_full <= 1'b0;
      end else if (wr_data) begin
         tx_data <= wdata_i;
         hold_full <= 1'b1;
      end else if (load) begin
         hold_full <= 1'b0;
      end
   end

   // Shifter state and frame length
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         state <= TX_IDLE;
         bits_left <= 4'h0;
      end else begin
         case (state)
            TX_IDLE: begin
               if (load) begin
                  state <= TX_SHIFT;
                  if (sync_mode) begin
                     bits_left <= nine_bit_transmit_select ? `FRAME_S9 : `FRAME_S8;
                  end else begin
                     bits_left <= nine_bit_transmit_select ? `FRAME_A9 : `FRAME_A8;
                  end
               end
            end
            TX_SHIFT: begin
               if (!tx_ready) begin
                  state <= TX_IDLE;
               end else if (bit_tick) begin
                  bits_left <= bits_left - 4'h1;
                  if (bits_left == `FRAME_LAST) begin
                     state <= TX_IDLE;
                  end
               end
            end
            default: begin
               state <= TX_IDLE;
            end
         endcase
      end
   end

   // Frame bits: start (async only), data low bit first, optional ninth, stop (async only)
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         shreg <= 11'h7ff;
      end else if (load && sync_mode) begin
         shreg <= {2'b11, ninth_transmit_bit, tx_data};
      end else if (load && nine_bit_transmit_select) begin
         shreg <= {1'b1, ninth_transmit_bit, tx_data, 1'b0};
      end else if (load) begin
         shreg <= {2'b11, tx_data, 1'b0};
      end else if (state == TX_SHIFT && bit_tick) begin
         shreg <= {1'b1, shreg[10:1]};
      end
   end

   // Line idles high; the bottom bit is on the line while shifting
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         tx_o <= 1'b1;
      end else if (load && !sync_mode) begin
         tx_o <= 1'b0;
      end else if (load) begin
         tx_o <= tx_data[0];
      end else if (state == TX_SHIFT && bit_tick) begin
         tx_o <= (bits_left == `FRAME_LAST) ? 1'b1 : shreg[1];
      end
   end

   // ----------------------------------------
   // Flags and interrupt
   // ----------------------------------------
   logic tx_event; // Holding register became free
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         transmit_enable_q <= 1'b0;
      end else begin
         transmit_enable_q <= transmit_enable;
      end
   end
   assign tx_event = (transmit_enable && !transmit_enable_q) || load;

   // Sticky flag, write one to clear; a new event wins
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         peripheral_flags_1 <= `FLAGS_RST;
      end else if (tx_event) begin
         peripheral_flags_1[`FLAG_TX] <= 1'b1;
      end else if (wr_flags && wdata_i[`FLAG_TX]) begin
         peripheral_flags_1[`FLAG_TX] <= 1'b0;
      end
   end

   assign irq_o = |(peripheral_flags_1 & peripheral_irq_enable_1);

   // ----------------------------------------
   // Read port
   // ----------------------------------------
   // Data stands only in the cycle after the read strobe
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         rdata_o <= `RD_ZERO;
      end else if (!rd_i) begin
         rdata_o <= `RD_ZERO;
      end else begin
         case (addr_i)
            `OFS_TXSC: begin
               rdata_o <= tx_status_control | {6'h00, shift_register_empty, 1'b0};
            end
            `OFS_RXSC: rdata_o <= rx_status_control;
            `OFS_DIV: rdata_o <= baud_divisor;
            `OFS_FLAGS: rdata_o <= peripheral_flags_1;
            `OFS_IRQEN: rdata_o <= peripheral_irq_enable_1;
            default: rdata_o <= `RD_ZERO;
         endcase
      end
   end

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!resetn_i);

   sequence data_write_s;
      wr_data && tx_ready && (state == TX_IDLE);
   endsequence
   sequence frame_load_s;
      hold_full && tx_ready && bit_tick && (state == TX_IDLE);
   endsequence

   div_clear_a: assert property (wr_div |=> gen_count == `DIV_RST && pre_cnt == `PRE_ZERO)
      else $error("divisor write did not clear the timer");
   gen_period_a: assert property (gen_tick |=> !gen_tick || baud_divisor == `DIV_RST)
      else $error("generator ticks back to back");
   async_low_a: assert property (int_bit_tick && !sync_mode && !high_speed_select
         |-> pre_cnt == `PRE_LOW)
      else $error("low speed bit not 64 ticks");
   async_high_a: assert property (int_bit_tick && !sync_mode && high_speed_select
         |-> pre_cnt == `PRE_HIGH)
      else $error("high speed bit not 16 ticks");
   sync_rate_a: assert property (int_bit_tick && sync_mode |-> pre_cnt == `PRE_SYNC)
      else $error("sync bit not 4 ticks");
   slave_clock_a: assert property (sync_mode && !clock_source_select |-> !gen_tick)
      else $error("generator runs in slave mode");
   transmit_enable_flag_a: assert property ($rose(transmit_enable) |=> peripheral_flags_1[`FLAG_TX])
      else $error("transmit enable did not set flag");
   tx_start_a: assert property (frame_load_s
         |=> state == TX_SHIFT && (sync_mode || !tx_o))
      else $error("frame did not start");
   hold_fill_a: assert property (data_write_s |=> hold_full)
      else $error("data write not held");
endmodule // uart_baud_tx

/* File: core/uart_baud_map.svh */
// Register offsets, field positions, reset values and counts of the baud generator block
`ifndef UART_BAUD_MAP_SVH
`define UART_BAUD_MAP_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define OFS_FLAGS 8'h0c
`define OFS_RXSC 8'h18
`define OFS_TXDATA 8'h19
`define OFS_IRQEN 8'h8c
`define OFS_TXSC 8'h98
`define OFS_DIV 8'h99

// ----------------------------------------
// Field positions
// ----------------------------------------
`define TXSC_CLOCK_SOURCE_SELECT 7
`define TXSC_TX9 6
`define TXSC_TRANSMIT_ENABLE 5
`define TXSC_SYNC 4
`define TXSC_HS 2
`define TXSC_SHIFT_REGISTER_EMPTY 1
`define TXSC_NINTH_TRANSMIT_BIT 0
`define RXSC_SERIAL_PORT_ENABLE 7
`define FLAG_TX 4

// ----------------------------------------
// Reset values and write masks
// ----------------------------------------
`define TXSC_RST 8'h02
`define RXSC_RST 8'h00
`define DIV_RST 8'h00
`define FLAGS_RST 8'h00
`define IRQEN_RST 8'h00
`define TXDATA_RST 8'h00
`define TXSC_WMASK 8'hf5
`define RXSC_WMASK 8'hf0
`define RD_ZERO 8'h00

// ----------------------------------------
// Prescaler limits (ratio minus one) and frame lengths
// ----------------------------------------
`define PRE_LOW 6'h3f
`define PRE_HIGH 6'h0f
`define PRE_SYNC 6'h03
`define PRE_HALF 6'h01
`define PRE_ZERO 6'h00
`define FRAME_A8 4'ha
`define FRAME_A9 4'hb
`define FRAME_S8 4'h8
`define FRAME_S9 4'h9
`define FRAME_LAST 4'h1

`endif

/* File: core/uart_baud_pkg.sv */
// Types shared by the baud generator and transmitter files
package uart_baud_pkg;
   // One register byte
   typedef logic [7:0] byte_t;
   // Transmit shifter states
   typedef enum logic [0:0] {
      TX_IDLE = 1'b0,
      TX_SHIFT = 1'b1
   } tx_state_t;
endpackage

/* File: core/baud_timer.sv */
// Free-running 8-bit timer whose period is the divisor plus one
`timescale 1ns/100ps
`include "uart_baud_map.svh"

module baud_timer (
   // Clock and reset
   input wire logic clk_i,
   input wire logic resetn_i,
   // Control
   input wire logic clear_i,
   input wire logic run_i,
   input wire uart_baud_pkg::byte_t divisor_i,
   // Result
   output logic tick_o,
   output uart_baud_pkg::byte_t count_o
);
   import uart_baud_pkg::*;

   // ----------------------------------------
   // Counter
   // ----------------------------------------
   // Tick when the count reaches the divisor
   assign tick_o = run_i && !clear_i && (count_o == divisor_i);

   // Count up, wrap at the divisor, clear on request
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         count_o <= `DIV_RST;
      end else if (clear_i || !run_i) begin
         count_o <= `DIV_RST;
      end else if (tick_o) begin
         count_o <= `DIV_RST;
      end else begin
         count_o <= count_o + 8'h01;
      end
   end
endmodule // baud_timer

/* File: verif/serial_rx_model.sv */
// Behavioural asynchronous receiver watching the serial line
`timescale 1ns/100ps

module serial_rx_model (
   // Clock and reset
   input wire logic clk_i,
   input wire logic resetn_i,
   // Line and frame shape
   input wire logic line_i,
   input wire logic [15:0] period_i,
   input wire logic nine_i,
   // Last frame and frame count
   output logic [8:0] data_o,
   output logic [7:0] frames_o,
   output logic stop_bad_o
);
   logic [8:0] shift; // Bits gathered so far
   int k; // Bit index

   // ----------------------------------------
   // Frame receiver
   // ----------------------------------------
   // Finds a start level, checks it at mid-bit, then samples each bit at its centre
   initial begin
      data_o = 9'h000;
      frames_o = 8'h00;
      stop_bad_o = 1'b0;
      forever begin
         @(posedge clk_i);
         if (resetn_i === 1'b1 && line_i === 1'b0) begin
            repeat (period_i / 2) @(posedge clk_i);
            // A glitch shorter than half a bit is not a start
            if (line_i === 1'b0) begin
               shift = 9'h000;
               for (k = 0; k < (nine_i ? 9 : 8); k++) begin
                  repeat (period_i) @(posedge clk_i);
                  shift[k] = line_i;
               end
               repeat (period_i) @(posedge clk_i);
               stop_bad_o <= (line_i !== 1'b1);
               data_o <= shift;
               frames_o <= frames_o + 8'h01;
            end
         end
      end
   end
endmodule // serial_rx_model

/* File: verif/uart_baud_tx_tb.sv */
// Self-checking bench for the baud generator and transmitter
`timescale 1ns/100ps
`include "uart_baud_map.svh"

module uart_baud_tx_tb;
   import uart_baud_pkg::*;
   // ----------------------------------------
   // Signals
   // ----------------------------------------
   logic clk_i; // Bench clock
   logic resetn_i; // Active-low reset
   byte_t addr; // Register address
   byte_t wdata; // Write data
   logic wr; // Write strobe
   logic rd; // Read strobe
   byte_t rdata; // Read data
   logic tx; // Serial line
   logic ck_out; // Bit clock out
   logic ck_oe; // Bit clock drive enable
   logic irq; // Interrupt level
   logic ck_in; // External bit clock
   logic [15:0] period; // Receiver bit length
   logic nine; // Receiver nine-bit frames
   logic [8:0] rx_data; // Last frame received
   logic [7:0] rx_frames; // Frames received
   logic rx_bad; // Stop bit error
   int err_total = 0; // Mismatches
   int check_count = 0; // Comparisons
   int cyc = 0; // Cycles run
   int n; // Wait length
   int len; // Level length
   byte_t ofs [0:6] = '{`OFS_FLAGS, `OFS_RXSC, `OFS_TXDATA, `OFS_IRQEN, `OFS_TXSC, `OFS_DIV,
      8'h20};
   byte_t rst [0:6] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h02, 8'h00, 8'h00};

   uart_baud_tx uart_baud_tx_i (.clk_i(clk_i), .resetn_i(resetn_i), .addr_i(addr),
      .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .tx_o(tx), .ck_i(ck_in),
      .ck_o(ck_out), .ck_oe_o(ck_oe), .irq_o(irq));
   serial_rx_model serial_rx_model_i (.clk_i(clk_i), .resetn_i(resetn_i), .line_i(tx),
      .period_i(period), .nine_i(nine), .data_o(rx_data), .frames_o(rx_frames),
      .stop_bad_o(rx_bad));

   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   // Verdict and end of run
   task automatic conclude();
      $display("checks %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   // Compare a byte from the design
   task automatic chk8(input byte_t got, input byte_t exp, input string what);
      check_count++;
      if (got !== exp) begin
         err_total++;
         $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask
   // Compare a cycle count measured by the bench
   task automatic chkn(input int got, input int lo, input int hi, input string what);
      check_count++;
      if (got < lo || got > hi) begin
         err_total++;
         $display("Error at %0t: %s count %0d not in %0d..%0d", $time, what, got, lo, hi);
      end
   endtask
   // Register write, then a quiet cycle so strobes never collide
   task automatic wr_reg(input byte_t a, input byte_t d);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk_i);
      wr <= 1'b0;
      @(posedge clk_i);
   endtask
   // Register read; data is taken mid-way through the cycle after the strobe
   task automatic rd_chk(input byte_t a, input byte_t exp, input string what);
      byte_t d;
      addr <= a;
      rd <= 1'b1;
      @(posedge clk_i);
      rd <= 1'b0;
      @(negedge clk_i);
      d = rdata;
      @(posedge clk_i);
      chk8(d, exp, what);
   endtask
   // Cycles until a pin falls, then its low time, or low plus high time
   task automatic span(input logic use_ck, input logic full, output int w, output int l);
      w = 0;
      l = 0;
      while ((use_ck ? ck_out : tx) !== 1'b0 && w < 20000) begin
         @(posedge clk_i);
         w++;
      end
      while ((use_ck ? ck_out : tx) === 1'b0 && l < 20000) begin
         @(posedge clk_i);
         l++;
      end
      while (full && (use_ck ? ck_out : tx) === 1'b1 && l < 20000) begin
         @(posedge clk_i);
         l++;
      end
   endtask
   // Wait for the next received frame and compare it
   task automatic frame(input logic [8:0] exp);
      logic [7:0] seen;
      int k;
      seen = rx_frames;
      k = 0;
      while (rx_frames === seen && k < 4000) begin
         @(posedge clk_i);
         k++;
      end
      chkn(k, 0, 3999, "frame wait");
      chk8(rx_data[7:0], exp[7:0], "frame data");
      chk8({6'h00, rx_bad, rx_data[8]}, {7'h00, exp[8]}, "ninth and stop bits");
   endtask
   // One low-then-high period on the external clock pin
   task automatic ck_pulse();
      ck_in <= 1'b0;
      repeat (4) @(posedge clk_i);
      ck_in <= 1'b1;
      repeat (5) @(posedge clk_i);
   endtask
   // End-of-test line
   task automatic done(input string name);
      $display("test %s done, mismatches so far %0d", name, err_total);
   endtask

   // ----------------------------------------
   // Clock and timeout
   // ----------------------------------------
   initial begin
      clk_i = 1'b0;
      forever begin
         #5 clk_i = ~clk_i;
      end
   end
   // Cuts a hang short
   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         err_total++;
         $display("Error at %0t: run did not finish", $time);
         conclude();
      end
   end

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      resetn_i = 1'b0;
      addr = 8'h00;
      wdata = 8'h00;
      wr = 1'b0;
      rd = 1'b0;
      ck_in = 1'b1;
      period = 16'h0040;
      nine = 1'b0;
      repeat (12) @(posedge clk_i);
      resetn_i <= 1'b1;
      @(posedge clk_i);
      // Reset values, the write-only data register and an unmapped place
      chk8({4'h0, tx, ck_out, ck_oe, irq}, 8'h0c, "pins after reset");
      for (int i = 0; i < 7; i++) begin
         rd_chk(ofs[i], rst[i], "reset value");
      end
      wr_reg(`OFS_DIV, 8'hff);
      rd_chk(`OFS_DIV, 8'hff, "divisor top");
      wr_reg(`OFS_RXSC, 8'hff);
      rd_chk(`OFS_RXSC, 8'hf0, "receive control");
      wr_reg(8'h20, 8'h5a);
      rd_chk(8'h20, 8'h00, "unmapped");
      done("registers");
      // Low-speed frame; the divisor write restarts the generator
      wr_reg(`OFS_DIV, 8'h03);
      wr_reg(`OFS_RXSC, 8'h80);
      wr_reg(`OFS_IRQEN, 8'h10);
      wr_reg(`OFS_TXSC, 8'h20);
      rd_chk(`OFS_FLAGS, 8'h10, "flag on enable");
      chk8({7'h00, irq}, 8'h01, "irq raised");
      wr_reg(`OFS_IRQEN, 8'h00);
      chk8({7'h00, irq}, 8'h00, "irq masked");
      wr_reg(`OFS_FLAGS, 8'h10);
      rd_chk(`OFS_FLAGS, 8'h00, "flag cleared");
      wr_reg(`OFS_IRQEN, 8'h10);
      chk8({7'h00, irq}, 8'h00, "irq after clear");
      repeat (90) @(posedge clk_i);
      wr_reg(`OFS_TXDATA, 8'ha5);
      wr_reg(`OFS_DIV, 8'h00);
      span(1'b0, 1'b0, n, len);
      chkn(n, 58, 70, "start after divisor write");
      chkn(len, 64, 64, "low-speed bit");
      frame(9'h0a5);
      repeat (80) @(posedge clk_i);
      rd_chk(`OFS_TXSC, 8'h22, "empty after frame");
      chk8({7'h00, irq}, 8'h01, "irq on load");
      done("low speed");
      // High-speed nine-bit frames sent back to back
      period <= 16'h0030;
      nine <= 1'b1;
      wr_reg(`OFS_DIV, 8'h02);
      wr_reg(`OFS_TXSC, 8'h65);
      wr_reg(`OFS_FLAGS, 8'h10);
      wr_reg(`OFS_TXDATA, 8'hc3);
      span(1'b0, 1'b0, n, len);
      chkn(len, 48, 48, "high-speed bit");
      rd_chk(`OFS_FLAGS, 8'h10, "holding free");
      rd_chk(`OFS_TXSC, 8'h65, "shifter busy");
      wr_reg(`OFS_TXDATA, 8'h3c);
      frame(9'h1c3);
      frame(9'h13c);
      done("high speed");
      // Synchronous master ignores the high-speed bit
      repeat (60) @(posedge clk_i);
      wr_reg(`OFS_DIV, 8'h01);
      wr_reg(`OFS_TXSC, 8'hb4);
      chk8({7'h00, ck_oe}, 8'h01, "clock drive on");
      wr_reg(`OFS_TXDATA, 8'hff);
      span(1'b1, 1'b1, n, len);
      chkn(len, 8, 8, "sync bit period");
      repeat (80) @(posedge clk_i);
      wr_reg(`OFS_TXSC, 8'h00);
      chk8({7'h00, ck_oe}, 8'h00, "clock drive off");
      done("synchronous");
      // Data written while transmit is off is dropped
      wr_reg(`OFS_TXDATA, 8'h00);
      n = 0;
      repeat (300) begin
         @(posedge clk_i);
         n += (tx !== 1'b1);
      end
      chkn(n, 0, 0, "line quiet");
      rd_chk(`OFS_TXDATA, 8'h00, "data reads zero");
      done("transmit off");
      // Synchronous slave: only the external clock moves the shifter
      wr_reg(`OFS_TXSC, 8'h30);
      chk8({7'h00, ck_oe}, 8'h00, "slave clock not driven");
      ck_pulse();
      rd_chk(`OFS_TXSC, 8'h32, "dropped word not sent");
      wr_reg(`OFS_TXDATA, 8'h02);
      repeat (40) @(posedge clk_i);
      chk8({7'h00, tx}, 8'h01, "no internal bit clock");
      ck_pulse();
      chk8({7'h00, tx}, 8'h00, "first bit on external edge");
      ck_pulse();
      chk8({7'h00, tx}, 8'h01, "second bit on external edge");
      rd_chk(`OFS_TXSC, 8'h30, "slave shifter busy");
      done("slave");
      conclude();
   end
endmodule // uart_baud_tx_tb
